/* File: tkc_consts.svh */
// register offsets, field positions and reset values of the transition key compositor
`ifndef TKC_CONSTS_SVH
`define TKC_CONSTS_SVH
`define TKC_A_CMD     8'h00
`define TKC_A_MODE    8'h04
`define TKC_A_RATE    8'h08
`define TKC_A_FRATE   8'h0c
`define TKC_A_KRATE   8'h10
`define TKC_A_NEXT    8'h14
`define TKC_A_KCFG    8'h18
`define TKC_A_SRC     8'h1c
`define TKC_A_STAT    8'h20
`define TKC_CMD_TAKE  0
`define TKC_CMD_CUT   1
`define TKC_CMD_PB    2
`define TKC_CMD_FTB   3
`define TKC_CMD_KMIX  4
`define TKC_MODE_LEV  2
`define TKC_MODE_LA   3
`define TKC_NXT_BG    4
`define TKC_NXT_PEN   5
`define TKC_NXT_PRI   6
`define TKC_KC_SELF   0
`define TKC_KC_SHP    1
`define TKC_KC_UNS    2
`define TKC_KC_MAT    3
`define TKC_KC_CLIP   16
`define TKC_KC_MLVL   24
`define TKC_RST_MODE  4'h1
`define TKC_RST_RATE  8'h1e
`define TKC_RST_KRATE 32'h1e1e1e1e
`define TKC_RST_PRI   8'he4
`define TKC_RST_SRC   16'h0100
`define TKC_STD_CLIP  8'h40
`define TKC_FULL      8'hff
`endif

/* File: tkc_pkg.sv */
// types shared by the transition key compositor
package tkc_pkg;
    typedef logic [7:0] tkc_pix_t;
    typedef enum logic [1:0] {
        TKC_IDLE = 2'b00,
        TKC_RUN  = 2'b01,
        TKC_DONE = 2'b10
    } tkc_st_e;
    typedef enum logic [1:0] {
        TKC_TY_CUT  = 2'b00,
        TKC_TY_MIX  = 2'b01,
        TKC_TY_WIPE = 2'b10
    } tkc_ty_e;
endpackage

/* File: tkc_top.sv */
// transition, key layering and fade-to-black compositor of one mix-effects stage
`timescale 1ns/1ns
`include "tkc_consts.svh"
module tkc_top
    import tkc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        frame_i,
    input  wire logic        pix_valid_i,
    input  wire logic [7:0]  bg_a_i,
    input  wire logic [7:0]  bg_b_i,
    input  wire logic [31:0] key_cut_i,
    input  wire logic [31:0] key_fill_i,
    input  wire logic [7:0]  wipe_i,
    input  wire logic [7:0]  lever_i,
    output tkc_pix_t         program_o,
    output tkc_pix_t         preview_o,
    output logic             pix_valid_o,
    output logic [7:0]       src_a_o,
    output logic [7:0]       src_b_o
);
    function automatic tkc_pix_t scale(input tkc_pix_t a, input tkc_pix_t b);
        logic [15:0] p;
        p = a * b;
        return 8'(p / 16'd255);
    endfunction
    function automatic tkc_pix_t sat(input tkc_pix_t a, input tkc_pix_t b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8] ? `TKC_FULL : s[7:0];
    endfunction
    function automatic tkc_pix_t frac(input logic [7:0] c, input logic [7:0] r);
        logic [15:0] p;
        p = c * `TKC_FULL;
        return (r == 8'h00) ? `TKC_FULL : 8'(p / {8'h00, r});
    endfunction
    function automatic tkc_pix_t udiv(input tkc_pix_t f, input tkc_pix_t a);
        logic [15:0] q;
        q = (a == 8'h00) ? 16'h0000 : (f * `TKC_FULL) / {8'h00, a};
        return (q > 16'h00ff) ? `TKC_FULL : q[7:0];
    endfunction
    // layers enabled keys in the order of the priority fields, so the key named in the last field sits on top
    function automatic tkc_pix_t comp(input tkc_pix_t bg, input logic [3:0] on,
                                      input logic [7:0] pri, input logic [31:0] al,
                                      input logic [31:0] fl);
        tkc_pix_t    acc;
        logic [1:0]  k;
        acc = bg;
        for (int i = 0; i < 4; i++) begin
            k = pri[i*2 +: 2];
            if (on[k]) begin
                acc = sat(scale(acc, ~al[{k, 3'b000} +: 8]), fl[{k, 3'b000} +: 8]);
            end
        end
        return acc;
    endfunction

    logic [3:0]  mode_r;
    logic [7:0]  rate_r;
    logic [7:0]  frate_r;
    logic [31:0] krate_r;
    logic [13:0] nsel_r;
    logic [31:0] kcfg_r;
    logic [15:0] src_r;
    logic        aw_h_r;
    logic        w_h_r;
    logic [7:0]  awa_r;
    logic [31:0] wd_r;
    logic [3:0]  ws_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [7:0]  lev_s1_r;
    logic [7:0]  lev_s2_r;
    tkc_st_e     st_r;
    logic [7:0]  cnt_r;
    logic        cut_r;
    logic        dir_r;
    logic [3:0]  cur_on_r;
    logic [7:0]  cur_pri_r;
    logic        black_r;
    logic        pb_arm_r;
    logic        ftb_on_r;
    logic        ftb_busy_r;
    logic [7:0]  ftb_cnt_r;
    logic        wr_go;
    logic        mapped_w;
    logic [7:0]  cmd;
    logic        done;
    logic        lever_md;
    tkc_pix_t    lev_w;
    tkc_pix_t    w_auto;
    tkc_pix_t    weight;
    tkc_pix_t    ftb_lvl;
    logic [3:0]  next_on;
    logic [7:0]  next_pri;
    logic [31:0] al;
    logic [31:0] fl;
    logic [3:0]  kset;
    logic [3:0]  kclr;
    tkc_pix_t    cur_c;
    tkc_pix_t    nx_c;
    tkc_pix_t    mixed;

    // register slave: address and data held until both arrive
    assign s_axi_awready_o = !aw_h_r && !bvalid_r;
    assign s_axi_wready_o  = !w_h_r && !bvalid_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign wr_go    = aw_h_r && w_h_r && !bvalid_r;
    assign mapped_w = awa_r[1:0] == 2'b00 && awa_r < `TKC_A_STAT;
    assign cmd      = (wr_go && awa_r == `TKC_A_CMD && ws_r[0]) ? wd_r[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            aw_h_r   <= 1'b0;
            w_h_r    <= 1'b0;
            awa_r    <= 8'h00;
            wd_r     <= 32'h0000_0000;
            ws_r     <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_h_r <= 1'b1;
                awa_r  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_h_r <= 1'b1;
                wd_r  <= s_axi_wdata_i;
                ws_r  <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_h_r   <= 1'b0;
                w_h_r    <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= mapped_w ? 2'b00 : 2'b10;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'b00;
            case (s_axi_araddr_i)
                `TKC_A_CMD:   rdata_r <= 32'h0000_0000;
                `TKC_A_MODE:  rdata_r <= {28'h0, mode_r};
                `TKC_A_RATE:  rdata_r <= {24'h0, rate_r};
                `TKC_A_FRATE: rdata_r <= {24'h0, frate_r};
                `TKC_A_KRATE: rdata_r <= krate_r;
                `TKC_A_NEXT:  rdata_r <= {18'h0, nsel_r};
                `TKC_A_KCFG:  rdata_r <= kcfg_r;
                `TKC_A_SRC:   rdata_r <= {16'h0, src_r};
                `TKC_A_STAT:  rdata_r <= {cur_pri_r, cur_on_r, ftb_lvl, ftb_busy_r,
                                          pb_arm_r, black_r, st_r != TKC_IDLE, weight};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= 2'b10;
                end
            endcase
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_r  <= `TKC_RST_MODE;
            rate_r  <= `TKC_RST_RATE;
            frate_r <= `TKC_RST_RATE;
            krate_r <= `TKC_RST_KRATE;
            nsel_r  <= {`TKC_RST_PRI, 6'h00};
            kcfg_r  <= {8'h00, `TKC_STD_CLIP, 16'h0000};
        end else if (wr_go) begin
            case (awa_r)
                `TKC_A_MODE:  mode_r  <= 4'(merge({28'h0, mode_r}, wd_r, ws_r));
                `TKC_A_RATE:  rate_r  <= 8'(merge({24'h0, rate_r}, wd_r, ws_r));
                `TKC_A_FRATE: frate_r <= 8'(merge({24'h0, frate_r}, wd_r, ws_r));
                `TKC_A_KRATE: krate_r <= merge(krate_r, wd_r, ws_r);
                `TKC_A_NEXT:  nsel_r  <= 14'(merge({18'h0, nsel_r}, wd_r, ws_r));
                `TKC_A_KCFG:  kcfg_r  <= merge(kcfg_r, wd_r, ws_r);
                default: ;
            endcase
        end
    end

    // a completed background transition swaps the bus selections
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            src_r <= `TKC_RST_SRC;
        end else if (done && !pb_arm_r && nsel_r[`TKC_NXT_BG]) begin
            src_r <= {src_r[7:0], src_r[15:8]};
        end else if (wr_go && awa_r == `TKC_A_SRC) begin
            src_r <= 16'(merge({16'h0, src_r}, wd_r, ws_r));
        end
    end
    assign src_a_o = src_r[7:0];
    assign src_b_o = src_r[15:8];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lev_s1_r <= 8'h00;
            lev_s2_r <= 8'h00;
        end else begin
            lev_s1_r <= lever_i;
            lev_s2_r <= lev_s1_r;
        end
    end

    assign lever_md = mode_r[`TKC_MODE_LEV];
    assign lev_w    = dir_r ? ~lev_s2_r : lev_s2_r;
    assign w_auto   = frac(cnt_r, rate_r);
    assign done     = st_r == TKC_DONE;
    always_comb begin
        case (st_r)
            TKC_RUN:  weight = cut_r ? 8'h00 : (lever_md ? lev_w : w_auto);
            TKC_DONE: weight = `TKC_FULL;
            default:  weight = 8'h00;
        endcase
    end

    // main transition sequencing
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r  <= TKC_IDLE;
            cnt_r <= 8'h00;
            cut_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            case (st_r)
                TKC_IDLE: begin
                    cnt_r <= 8'h00;
                    if (cmd[`TKC_CMD_TAKE] || cmd[`TKC_CMD_CUT]) begin
                        st_r  <= TKC_RUN;
                        cut_r <= cmd[`TKC_CMD_CUT] || mode_r[1:0] == TKC_TY_CUT;
                    end else if (lever_md && lev_w != 8'h00) begin
                        st_r  <= TKC_RUN;
                        cut_r <= 1'b0;
                    end
                end
                TKC_RUN: begin
                    if (lever_md && !cut_r) begin
                        if (lev_w == `TKC_FULL) st_r <= TKC_DONE;
                    end else if (frame_i) begin
                        if (cut_r || 9'(cnt_r) + 9'd1 >= 9'(rate_r)) begin
                            st_r <= TKC_DONE;
                        end else begin
                            cnt_r <= cnt_r + 8'd1;
                        end
                    end
                end
                TKC_DONE: begin
                    st_r <= TKC_IDLE;
                    if (lever_md && !cut_r) dir_r <= !dir_r;
                end
                default: st_r <= TKC_IDLE;
            endcase
        end
    end

    // preset black: arm, take into black, then a second take out of it
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pb_arm_r <= 1'b0;
            black_r  <= 1'b0;
        end else if (done) begin
            // an arm request landing on a completion cycle still arms, unless that completion is a take into or out of black
            pb_arm_r <= cmd[`TKC_CMD_PB] && !pb_arm_r && !black_r;
            black_r  <= pb_arm_r;
        end else if (cmd[`TKC_CMD_PB] && !black_r) begin
            pb_arm_r <= 1'b1;
        end
    end

    assign next_on  = cur_on_r ^ nsel_r[3:0];
    assign next_pri = nsel_r[`TKC_NXT_PEN] ? nsel_r[`TKC_NXT_PRI +: 8] : cur_pri_r;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cur_on_r  <= 4'h0;
            cur_pri_r <= `TKC_RST_PRI;
        end else if (done && !pb_arm_r) begin
            cur_on_r  <= next_on;
            cur_pri_r <= next_pri;
        end else begin
            cur_on_r <= (cur_on_r | kset) & ~kclr;
        end
    end

    // downstream keyer fade to black
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ftb_on_r   <= 1'b0;
            ftb_busy_r <= 1'b0;
            ftb_cnt_r  <= 8'h00;
        end else if (!ftb_busy_r) begin
            ftb_cnt_r <= 8'h00;
            if (cmd[`TKC_CMD_FTB]) ftb_busy_r <= 1'b1;
        end else if (frame_i) begin
            if (9'(ftb_cnt_r) + 9'd1 >= 9'(frate_r)) begin
                ftb_busy_r <= 1'b0;
                ftb_on_r   <= !ftb_on_r;
            end else begin
                ftb_cnt_r <= ftb_cnt_r + 8'd1;
            end
        end
    end
    always_comb begin
        if (ftb_busy_r) begin
            ftb_lvl = ftb_on_r ? ~frac(ftb_cnt_r, frate_r) : frac(ftb_cnt_r, frate_r);
        end else begin
            ftb_lvl = ftb_on_r ? `TKC_FULL : 8'h00;
        end
    end

    // per keyer: key control, fill shaping and its own key mix
    for (genvar k = 0; k < 4; k++) begin : g_key
        logic [3:0] cf;
        logic [7:0] cut;
        logic [7:0] clipv;
        logic [7:0] a;
        logic [7:0] f0;
        logic [7:0] sf;
        logic [7:0] lvl;
        logic [7:0] kw;
        logic       busy_r;
        logic       in_r;
        logic [7:0] kc_r;
        assign cf    = kcfg_r[k*4 +: 4];
        assign cut   = cf[`TKC_KC_SELF] ? key_fill_i[k*8 +: 8] : key_cut_i[k*8 +: 8];
        assign clipv = cf[`TKC_KC_SHP] ? `TKC_STD_CLIP : kcfg_r[`TKC_KC_CLIP +: 8];
        assign a     = (cut > clipv) ? cut : 8'h00;
        assign f0    = cf[`TKC_KC_MAT] ? kcfg_r[`TKC_KC_MLVL +: 8] : key_fill_i[k*8 +: 8];
        always_comb begin
            if (cf[`TKC_KC_SHP] && !cf[`TKC_KC_UNS]) begin
                sf = f0;
            end else if (cf[`TKC_KC_SHP]) begin
                sf = scale(udiv(f0, a), a);
            end else begin
                sf = scale(f0, a);
            end
        end
        assign kw  = frac(kc_r, krate_r[k*8 +: 8]);
        assign lvl = busy_r ? (in_r ? kw : ~kw) : `TKC_FULL;
        assign al[k*8 +: 8] = scale(a, lvl);
        assign fl[k*8 +: 8] = scale(sf, lvl);
        assign kset[k] = cmd[`TKC_CMD_KMIX + k] && !busy_r && !cur_on_r[k];
        assign kclr[k] = busy_r && !in_r && frame_i
                         && 9'(kc_r) + 9'd1 >= 9'(krate_r[k*8 +: 8]);
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                busy_r <= 1'b0;
                in_r   <= 1'b0;
                kc_r   <= 8'h00;
            end else if (!busy_r) begin
                kc_r <= 8'h00;
                if (cmd[`TKC_CMD_KMIX + k] && st_r == TKC_IDLE) begin
                    busy_r <= 1'b1;
                    in_r   <= !cur_on_r[k];
                end
            end else if (frame_i) begin
                if (9'(kc_r) + 9'd1 >= 9'(krate_r[k*8 +: 8])) busy_r <= 1'b0;
                else kc_r <= kc_r + 8'd1;
            end
        end
    end

    // whole composites, each key at its own key-mix level, layered by priority
    assign cur_c = black_r ? 8'h00 : comp(bg_a_i, cur_on_r, cur_pri_r, al, fl);
    assign nx_c  = pb_arm_r ? 8'h00
                 : comp(nsel_r[`TKC_NXT_BG] ? bg_b_i : bg_a_i, next_on, next_pri, al, fl);
    always_comb begin
        if (mode_r[1:0] == TKC_TY_WIPE && !cut_r && st_r == TKC_RUN) begin
            mixed = (wipe_i < weight) ? nx_c : cur_c;
        end else begin
            mixed = sat(scale(cur_c, ~weight), scale(nx_c, weight));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            program_o   <= 8'h00;
            preview_o   <= 8'h00;
            pix_valid_o <= 1'b0;
        end else begin
            pix_valid_o <= pix_valid_i;
            if (pix_valid_i) begin
                program_o <= scale(mixed, ~ftb_lvl);
                preview_o <= mode_r[`TKC_MODE_LA] ? nx_c : bg_b_i;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    pb_halves_a: assert property (done && pb_arm_r |=> black_r && !pb_arm_r)
        else $error("preset black did not land in black");
    pb_black_a: assert property (black_r && st_r == TKC_IDLE && pix_valid_i
        |=> program_o == 8'h00) else $error("program not black while in black");
    ftb_black_a: assert property (ftb_on_r && !ftb_busy_r && pix_valid_i
        |=> program_o == 8'h00) else $error("program not black after fade");
    cut_frame_a: assert property (st_r == TKC_RUN && cut_r && frame_i
        |=> done ##1 st_r == TKC_IDLE) else $error("cut did not finish at frame");
    rate_end_a: assert property (st_r == TKC_RUN && !lever_md && frame_i
        && 9'(cnt_r) + 9'd1 >= 9'(rate_r) |=> done) else $error("timed end missed");
    lever_follow_a: assert property (st_r == TKC_RUN && lever_md && !cut_r
        |-> weight == lev_w) else $error("weight does not follow lever");
    bus_swap_a: assert property (done && !pb_arm_r && nsel_r[`TKC_NXT_BG]
        |=> src_r == {$past(src_r[7:0]), $past(src_r[15:8])}) else $error("no bus swap");
    look_ahead_a: assert property (mode_r[`TKC_MODE_LA] && pix_valid_i
        |=> preview_o == $past(nx_c)) else $error("preview is not next stack");
    next_stack_a: assert property (done && !pb_arm_r |=> cur_on_r == $past(next_on)
        && cur_pri_r == $past(next_pri)) else $error("stack not advanced");
    progress_up_a: assert property (st_r == TKC_RUN && !lever_md && !frame_i
        |=> $stable(cnt_r)) else $error("progress moved off frame");
    axi_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    done_cv: cover property (done && !pb_arm_r && nsel_r[`TKC_NXT_BG]);
    pb_cv: cover property (done && pb_arm_r);
    ftb_cv: cover property (ftb_busy_r && frame_i);
    kmix_cv: cover property (kset != 4'h0);
endmodule

/* File: tkc_src_model.sv */
// video sources and frame timing in front of the compositor
`timescale 1ns/1ns
module tkc_src_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  src_a_i,
    input  wire logic [7:0]  src_b_i,
    input  wire logic [7:0]  cut_i,
    output logic             frame_o,
    output logic             pix_o,
    output logic [7:0]       bg_a_o,
    output logic [7:0]       bg_b_o,
    output logic [7:0]       wipe_o,
    output logic [31:0]      cut_o,
    output logic [31:0]      fill_o
);
    logic [5:0] cnt_r = 6'h00;
    // one frame pulse every 40 clocks
    always_ff @(posedge clk_i) begin
        cnt_r <= (cnt_r == 6'h27) ? 6'h00 : cnt_r + 6'h01;
    end
    assign frame_o = (cnt_r == 6'h27);
    assign pix_o   = 1'b1;
    // each routed source shows its own flat level
    assign bg_a_o  = {src_a_i[3:0] + 4'h1, 4'h0};
    assign bg_b_o  = {src_b_i[3:0] + 4'h1, 4'h0};
    assign wipe_o  = 8'h80;
    assign cut_o   = {4{cut_i}};
    assign fill_o  = 32'h83828180;
endmodule

/* File: transition_key_compositor_bench.sv */
// self-checking bench of the transition key compositor
`timescale 1ns/1ns
`include "tkc_consts.svh"
module transition_key_compositor_bench
    import tkc_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, lever_i = 8'h00, cut = 8'hff;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, frame_i, pix_valid_i, pix_valid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o, key_cut_i, key_fill_i;
    logic [7:0]  bg_a_i, bg_b_i, wipe_i, src_a_o, src_b_o;
    tkc_pix_t    program_o, preview_o;
    int          error_cnt = 0, n_checks = 0;
    logic [31:0] rst_v [7] = '{32'h1, 32'h1e, 32'h1e, 32'h1e1e1e1e, 32'h3900, 32'h00400000, 32'h100};
    // key 1 kinds: unshaped, self, matte, shaped then unshaped; key level 0x80 over 0x10
    logic [31:0] kc_v [4] = '{32'h0, 32'h10, 32'h80, 32'h60};
    logic [7:0]  kx_v [4] = '{8'h47, 8'h48, 8'h37, 8'h87};
    tkc_top i_tkc_top (.clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .frame_i, .pix_valid_i,
        .bg_a_i, .bg_b_i, .key_cut_i, .key_fill_i, .wipe_i, .lever_i, .program_o, .preview_o,
        .pix_valid_o, .src_a_o, .src_b_o);
    tkc_src_model i_tkc_src_model (.clk_i(clk_i), .src_a_i(src_a_o), .src_b_i(src_b_o),
        .cut_i(cut), .frame_o(frame_i), .pix_o(pix_valid_i), .bg_a_o(bg_a_i), .bg_b_o(bg_b_i),
        .wipe_o(wipe_i), .cut_o(key_cut_i), .fill_o(key_fill_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ha, hw, hb;
        logic [1:0] rs;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(negedge clk_i);
            ha = s_axi_awready_o;
            hw = s_axi_wready_o;
            hb = s_axi_bvalid_o;
            rs = s_axi_bresp_o;
            @(posedge clk_i);
            if (ha) s_axi_awvalid_i <= 1'b0;
            if (hw) s_axi_wvalid_i <= 1'b0;
        end while (!hb);
        s_axi_bready_i <= 1'b0;
        chk(rs, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
        logic ha, hb;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(negedge clk_i);
            ha = s_axi_arready_o;
            hb = s_axi_rvalid_o;
            d = s_axi_rdata_o;
            rs = s_axi_rresp_o;
            @(posedge clk_i);
            if (ha) s_axi_arvalid_i <= 1'b0;
        end while (!hb);
        s_axi_rready_i <= 1'b0;
        chk(d & m, e);
        chk(rs, r);
    endtask
    task automatic fr(input int n);
        repeat (n) @(posedge frame_i);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'h04 + 8'(4 * i), '1, rst_v[i], 2'b00);
        rd(8'h40, '1, 32'h0, 2'b10);
        wr(8'h40, 32'h1, 2'b10);
        chk(program_o, 8'h10);
        wr(`TKC_A_MODE, 32'h0, 2'b00);
        wr(`TKC_A_NEXT, 32'h10, 2'b00);
        wr(`TKC_A_CMD, 32'h2, 2'b00);
        fr(2);
        chk({src_a_o, src_b_o, program_o}, 24'h010020);
        $display("cut done");
        wr(`TKC_A_RATE, 32'h2, 2'b00);
        for (int t = 1; t < 3; t++) begin
            wr(`TKC_A_MODE, 32'(t), 2'b00);
            @(posedge frame_i);
            wr(`TKC_A_CMD, 32'h1, 2'b00);
            fr(1);
            rd(`TKC_A_STAT, 32'h100, 32'h100, 2'b00);
            fr(1);
            rd(`TKC_A_STAT, 32'h100, 32'h0, 2'b00);
            chk(src_a_o, (t == 2) ? 1 : 0);
        end
        $display("timed done");
        wr(`TKC_A_MODE, 32'h9, 2'b00);
        wr(`TKC_A_NEXT, 32'h0, 2'b00);
        repeat (2) @(posedge clk_i);
        chk(preview_o, 8'h20);
        wr(`TKC_A_NEXT, 32'h10, 2'b00);
        repeat (2) @(posedge clk_i);
        chk(preview_o, 8'h10);
        chk(pix_valid_o, 1);
        $display("preview done");
        wr(`TKC_A_KCFG, 32'h00100022, 2'b00);
        wr(`TKC_A_MODE, 32'h0, 2'b00);
        wr(`TKC_A_NEXT, 32'h3, 2'b00);
        wr(`TKC_A_CMD, 32'h2, 2'b00);
        fr(2);
        chk(program_o, 8'h81);
        cut <= 8'h20;
        repeat (3) @(posedge clk_i);
        chk(program_o, 8'hff);
        cut <= 8'hff;
        wr(`TKC_A_NEXT, 32'he60, 2'b00);
        wr(`TKC_A_CMD, 32'h2, 2'b00);
        fr(2);
        chk(program_o, 8'h80);
        wr(`TKC_A_KRATE, 32'h1, 2'b00);
        wr(`TKC_A_CMD, 32'h10, 2'b00);
        fr(2);
        chk(program_o, 8'h81);
        $display("keys done");
        wr(`TKC_A_NEXT, 32'h0, 2'b00);
        wr(`TKC_A_CMD, 32'h4, 2'b00);
        for (int k = 0; k < 2; k++) begin
            wr(`TKC_A_CMD, 32'h1, 2'b00);
            fr(2);
            chk(program_o, k ? 8'h81 : 8'h00);
        end
        wr(`TKC_A_FRATE, 32'h1, 2'b00);
        for (int k = 0; k < 2; k++) begin
            wr(`TKC_A_CMD, 32'h8, 2'b00);
            fr(2);
            chk(program_o, k ? 8'h81 : 8'h00);
        end
        $display("black done");
        wr(`TKC_A_NEXT, 32'h10, 2'b00);
        wr(`TKC_A_MODE, 32'h5, 2'b00);
        lever_i <= 8'hff;
        fr(2);
        chk(src_a_o, 0);
        $display("lever done");
        cut <= 8'h80;
        for (int c = 0; c < 4; c++) begin
            wr(`TKC_A_KCFG, 32'h60100000 | kc_v[c], 2'b00);
            repeat (3) @(posedge clk_i);
            chk(program_o, kx_v[c]);
        end
        $display("shaping done");
        end_of_test();
    end
endmodule
